// [src/timer_capture_compare_unit.sv]
// Two capture and two compare channels of a 16-bit timer with its free-running counter.
// Assumes an APB master on clk, synchronous pins, and the CPU global mask as a level input.
//
// Contract
// - Two 16-bit captures latch counter on edge.
// - Capture values are read-only to software.
// - Per-channel edge select picks rising/falling.
// - Capture sets flag; interrupt gated by enable/mask.
// - Capture flag clears: status read, then low access.
// - High byte read blocks capture until low read.
// - Capture register holds most recent capture.
// - One capture interrupt enable for both channels.
// - One-pulse/PWM: only capture channel 2 works.
// - Pins always feed capture; high read disables.
// - Counter ticks at clk/2,/4,/8 or on external pin edge per select.
// - Both compare registers checked every timer tick.
// - Compare registers software-only; reset 8000h.
// - Match sets flag, drives level, interrupt gated.
// - Compare pin latches low during reset.
// - Compare flag clears: status read, then low access.
// - High byte write inhibits compare until low.
// - Pin disabled: no level, interrupt still possible.
// - Div2 matches at value; others value plus one.
// - Force copies level, no flag, no interrupt.
// - Force ignored in one-pulse or PWM mode.
// - Overflow flag set on FFFFh to 0000h wrap.
// - Counter low write reloads counter with FFFCh.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic [1:0] capture_input_pin,
  input wire logic ext_clock_pin,
  output logic [1:0] compare_output_pin,
  output logic [1:0] compare_pin_enable,
  // Interrupt request and CPU global mask
  input wire logic cpu_irq_mask,
  output logic timer_irq
);
  logic [7:0] ctrl_one_reg;
  logic [7:0] ctrl_two_reg;
  logic [15:0] counter_reg;
  logic [2:0] presc_reg;
  logic [1:0] ext_sync_reg;
  logic ext_prev_reg;
  logic tick_d_reg;
  logic [1:0] cap_s1_reg;
  logic [1:0] cap_s2_reg;
  logic [1:0] cap_prev_reg;
  logic [15:0] capture_value_reg [2];
  logic [15:0] compare_value_reg [2];
  logic [1:0] cap_block_reg;
  logic [1:0] cmp_inhibit_reg;
  logic [1:0] capture_flag_reg;
  logic [1:0] compare_flag_reg;
  logic overflow_flag_reg;
  logic [1:0] cap_arm_reg;
  logic [1:0] cmp_arm_reg;
  logic ovf_arm_reg;
  logic [7:0] lo_buf_reg;
  logic lo_buf_valid_reg;
  logic [1:0] pin_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic mode_active;
  logic tick;
  logic ext_edge;
  logic [1:0] edge_sel;
  logic [1:0] level;
  logic [1:0] pin_en;
  logic [1:0] cap_evt;
  logic [1:0] cmp_match;
  logic [1:0] cap_lo_acc;
  logic [1:0] cap_hi_rd;
  logic [1:0] cmp_lo_acc;
  logic [1:0] cmp_hi_wr;
  logic [1:0] cmp_lo_wr;
  logic flags_rd;
  logic force_wr;
  logic cnt_lo_wr;
  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign pready = 1'b1;
  assign mode_active = ctrl_two_reg[tcc_pkg::C2_OPM] | ctrl_two_reg[tcc_pkg::C2_PWM];
  assign edge_sel = {ctrl_one_reg[tcc_pkg::C1_EDGE2], ctrl_one_reg[tcc_pkg::C1_EDGE1]};
  assign level = {ctrl_one_reg[tcc_pkg::C1_LEVEL2], ctrl_one_reg[tcc_pkg::C1_LEVEL1]};
  assign pin_en = {ctrl_two_reg[tcc_pkg::C2_PIN_EN2], ctrl_two_reg[tcc_pkg::C2_PIN_EN1]};
  assign flags_rd = rd & (paddr == tcc_pkg::OFS_FLAGS);
  assign force_wr = wr & (paddr == tcc_pkg::OFS_FORCE);
  assign cnt_lo_wr = wr & ((paddr == tcc_pkg::OFS_CNT_LO) | (paddr == tcc_pkg::OFS_ALT_LO));
  assign cap_lo_acc = {access & (paddr == tcc_pkg::OFS_CAP2_LO), access & (paddr == tcc_pkg::OFS_CAP1_LO)};
  assign cap_hi_rd = {rd & (paddr == tcc_pkg::OFS_CAP2_HI), rd & (paddr == tcc_pkg::OFS_CAP1_HI)};
  assign cmp_lo_acc = {access & (paddr == tcc_pkg::OFS_CMP2_LO), access & (paddr == tcc_pkg::OFS_CMP1_LO)};
  assign cmp_hi_wr = {wr & (paddr == tcc_pkg::OFS_CMP2_HI), wr & (paddr == tcc_pkg::OFS_CMP1_HI)};
  assign cmp_lo_wr = {wr & (paddr == tcc_pkg::OFS_CMP2_LO), wr & (paddr == tcc_pkg::OFS_CMP1_LO)};
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= tcc_pkg::OFS_FORCE);
  assign pslverr = access & ~mapped;
  assign prdata = prdata_reg;
  always_comb begin
    prdata_next = 32'h0000_0000;
    case (paddr)
      tcc_pkg::OFS_CTRL_TWO: prdata_next[7:0] = ctrl_two_reg;
      tcc_pkg::OFS_CTRL_ONE: prdata_next[7:0] = ctrl_one_reg;
      tcc_pkg::OFS_FLAGS: begin
        prdata_next[tcc_pkg::F_CAP1] = capture_flag_reg[0];
        prdata_next[tcc_pkg::F_CMP1] = compare_flag_reg[0];
        prdata_next[tcc_pkg::F_OVF] = overflow_flag_reg;
        prdata_next[tcc_pkg::F_CAP2] = capture_flag_reg[1];
        prdata_next[tcc_pkg::F_CMP2] = compare_flag_reg[1];
      end
      tcc_pkg::OFS_CAP1_HI: prdata_next[7:0] = capture_value_reg[0][15:8];
      tcc_pkg::OFS_CAP1_LO: prdata_next[7:0] = capture_value_reg[0][7:0];
      tcc_pkg::OFS_CAP2_HI: prdata_next[7:0] = capture_value_reg[1][15:8];
      tcc_pkg::OFS_CAP2_LO: prdata_next[7:0] = capture_value_reg[1][7:0];
      tcc_pkg::OFS_CMP1_HI: prdata_next[7:0] = compare_value_reg[0][15:8];
      tcc_pkg::OFS_CMP1_LO: prdata_next[7:0] = compare_value_reg[0][7:0];
      tcc_pkg::OFS_CMP2_HI: prdata_next[7:0] = compare_value_reg[1][15:8];
      tcc_pkg::OFS_CMP2_LO: prdata_next[7:0] = compare_value_reg[1][7:0];
      tcc_pkg::OFS_CNT_HI, tcc_pkg::OFS_ALT_HI: prdata_next[7:0] = counter_reg[15:8];
      tcc_pkg::OFS_CNT_LO, tcc_pkg::OFS_ALT_LO: prdata_next[7:0] = lo_buf_valid_reg ? lo_buf_reg : counter_reg[7:0];
      default: prdata_next = 32'h0000_0000;
    endcase
  end
  // Read data is prepared in the setup cycle and stands through the access cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= prdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_one_reg <= tcc_pkg::CTRL_RESET;
      ctrl_two_reg <= tcc_pkg::CTRL_RESET;
    end else begin
      if (wr && paddr == tcc_pkg::OFS_CTRL_ONE) begin
        ctrl_one_reg <= pwdata[7:0];
      end
      if (wr && paddr == tcc_pkg::OFS_CTRL_TWO) begin
        ctrl_two_reg <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and free-running counter
  // ----------------------------------------------------------------
  assign ext_edge = ctrl_two_reg[tcc_pkg::C2_EXT_EDGE] ? (ext_sync_reg[1] & ~ext_prev_reg)
                                                       : (~ext_sync_reg[1] & ext_prev_reg);

  always_comb begin
    case (tcc_pkg::clk_sel_type'(ctrl_two_reg[tcc_pkg::C2_CLKSEL_LO +: 2]))
      tcc_pkg::CLK_DIV2: tick = presc_reg[0];
      tcc_pkg::CLK_DIV4: tick = &presc_reg[1:0];
      tcc_pkg::CLK_DIV8: tick = &presc_reg;
      tcc_pkg::CLK_EXT: tick = ext_edge;
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      presc_reg <= 3'h0;
      ext_sync_reg <= 2'h0;
      ext_prev_reg <= 1'b0;
      tick_d_reg <= 1'b0;
    end else begin
      presc_reg <= presc_reg + 3'h1;
      ext_sync_reg <= {ext_sync_reg[0], ext_clock_pin};
      ext_prev_reg <= ext_sync_reg[1];
      tick_d_reg <= tick & ~cnt_lo_wr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      counter_reg <= tcc_pkg::CNT_RELOAD;
    end else if (cnt_lo_wr) begin
      counter_reg <= tcc_pkg::CNT_RELOAD;
    end else if (tick) begin
      counter_reg <= counter_reg + 16'h0001;
    end
  end
  // Reading the counter high byte freezes the low byte until it is read.
  always_ff @(posedge clk) begin
    if (rst) begin
      lo_buf_reg <= 8'h00;
      lo_buf_valid_reg <= 1'b0;
    end else if (rd && (paddr == tcc_pkg::OFS_CNT_HI || paddr == tcc_pkg::OFS_ALT_HI)) begin
      if (!lo_buf_valid_reg) begin
        lo_buf_reg <= counter_reg[7:0];
      end
      lo_buf_valid_reg <= 1'b1;
    end else if (rd && (paddr == tcc_pkg::OFS_CNT_LO || paddr == tcc_pkg::OFS_ALT_LO)) begin
      lo_buf_valid_reg <= 1'b0;
    end
  end
  // Overflow flag: set wins over the two-step clear, which only the counter low byte does.
  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_flag_reg <= 1'b0;
      ovf_arm_reg <= 1'b0;
    end else begin
      if (tick && !cnt_lo_wr && counter_reg == tcc_pkg::CNT_TOP) begin
        overflow_flag_reg <= 1'b1;
      end else if (ovf_arm_reg && access && paddr == tcc_pkg::OFS_CNT_LO) begin
        overflow_flag_reg <= 1'b0;
      end
      if (flags_rd) begin
        ovf_arm_reg <= overflow_flag_reg;
      end else if (access && paddr == tcc_pkg::OFS_CNT_LO) begin
        ovf_arm_reg <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Capture and compare channels
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_chan
    logic [15:0] target;
    assign cap_evt[i] = (edge_sel[i] ? (cap_s2_reg[i] & ~cap_prev_reg[i])
                                     : (~cap_s2_reg[i] & cap_prev_reg[i]))
                        & ~cap_block_reg[i] & ~(mode_active && i == 0);
    assign target = (ctrl_two_reg[tcc_pkg::C2_CLKSEL_LO +: 2] == tcc_pkg::CLK_DIV2)
                    ? compare_value_reg[i] : compare_value_reg[i] + 16'h0001;
    assign cmp_match[i] = tick_d_reg & ~cmp_inhibit_reg[i] & (counter_reg == target);
    always_ff @(posedge clk) begin
      if (rst) begin
        cap_s1_reg[i] <= 1'b0;
        cap_s2_reg[i] <= 1'b0;
        cap_prev_reg[i] <= 1'b0;
      end else begin
        cap_s1_reg[i] <= capture_input_pin[i];
        cap_s2_reg[i] <= cap_s1_reg[i];
        cap_prev_reg[i] <= cap_s2_reg[i];
      end
    end
    // Capture value: only hardware writes it; the newest event overwrites the older one.
    always_ff @(posedge clk) begin
      if (rst) begin
        capture_value_reg[i] <= 16'h0000;
      end else if (cap_evt[i]) begin
        capture_value_reg[i] <= counter_reg;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        cap_block_reg[i] <= 1'b0;
      end else if (cap_hi_rd[i]) begin
        cap_block_reg[i] <= 1'b1;
      end else if (cap_lo_acc[i] && !pwrite) begin
        cap_block_reg[i] <= 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        capture_flag_reg[i] <= 1'b0;
        cap_arm_reg[i] <= 1'b0;
      end else begin
        if (cap_evt[i]) begin
          capture_flag_reg[i] <= 1'b1;
        end else if (cap_arm_reg[i] && cap_lo_acc[i]) begin
          capture_flag_reg[i] <= 1'b0;
        end
        if (flags_rd) begin
          cap_arm_reg[i] <= capture_flag_reg[i];
        end else if (cap_lo_acc[i]) begin
          cap_arm_reg[i] <= 1'b0;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        compare_value_reg[i] <= tcc_pkg::CMP_RESET;
      end else if (cmp_hi_wr[i]) begin
        compare_value_reg[i][15:8] <= pwdata[7:0];
      end else if (cmp_lo_wr[i]) begin
        compare_value_reg[i][7:0] <= pwdata[7:0];
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        cmp_inhibit_reg[i] <= 1'b0;
      end else if (cmp_hi_wr[i]) begin
        cmp_inhibit_reg[i] <= 1'b1;
      end else if (cmp_lo_wr[i]) begin
        cmp_inhibit_reg[i] <= 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        compare_flag_reg[i] <= 1'b0;
        cmp_arm_reg[i] <= 1'b0;
      end else begin
        if (cmp_match[i]) begin
          compare_flag_reg[i] <= 1'b1;
        end else if (cmp_arm_reg[i] && cmp_lo_acc[i]) begin
          compare_flag_reg[i] <= 1'b0;
        end
        if (flags_rd) begin
          cmp_arm_reg[i] <= compare_flag_reg[i];
        end else if (cmp_lo_acc[i]) begin
          cmp_arm_reg[i] <= 1'b0;
        end
      end
    end
    // Pin latch: a match with the pin enabled, or a force outside one-pulse/PWM mode, copies the level; a force leaves the flag alone.
    always_ff @(posedge clk) begin
      if (rst) begin
        pin_reg[i] <= 1'b0;
      end else if (cmp_match[i] && pin_en[i]) begin
        pin_reg[i] <= level[i];
      end else if (force_wr && pwdata[i] && !mode_active) begin
        pin_reg[i] <= level[i];
      end
    end
  end
  assign compare_output_pin = pin_reg;
  assign compare_pin_enable = pin_en;

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  assign timer_irq = ~cpu_irq_mask & (
    (ctrl_one_reg[tcc_pkg::C1_CAP_IE] & (|capture_flag_reg)) |
    (ctrl_one_reg[tcc_pkg::C1_CMP_IE] & (|compare_flag_reg)) |
    (ctrl_one_reg[tcc_pkg::C1_OVF_IE] & overflow_flag_reg));

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  cap_latch_a: assert property (cap_evt[0] |=> capture_value_reg[0] == $past(counter_reg))
    else $error("capture 1 did not latch the counter");
  cap_readonly_a: assert property ((wr && paddr == tcc_pkg::OFS_CAP2_LO && !cap_evt[1])
    |=> $stable(capture_value_reg[1]))
    else $error("capture 2 changed on a software write");
  cap_irq_a: assert property ((capture_flag_reg[1] && ctrl_one_reg[tcc_pkg::C1_CAP_IE] && !cpu_irq_mask)
    |-> timer_irq)
    else $error("capture interrupt not requested");
  cap_block_a: assert property (cap_block_reg[0] |=>
    !$rose(capture_flag_reg[0]) && $stable(capture_value_reg[0]))
    else $error("capture 1 flag set while blocked");
  cap_mode_a: assert property (mode_active |-> !cap_evt[0])
    else $error("capture 1 ran in pulse mode");
  cmp_reset_a: assert property ($fell(rst) |-> compare_value_reg[0] == tcc_pkg::CMP_RESET
    && compare_output_pin == 2'h0)
    else $error("compare reset state wrong");
  cmp_inhibit_a: assert property (cmp_hi_wr[1] |=> cmp_inhibit_reg[1] && !cmp_match[1])
    else $error("compare 2 matched while inhibited");
  cmp_flag_a: assert property (cmp_match[0] |=> compare_flag_reg[0])
    else $error("compare 1 flag not set on match");
  ovf_wrap_a: assert property ((tick && !cnt_lo_wr && counter_reg == tcc_pkg::CNT_TOP)
    |=> counter_reg == 16'h0000 && overflow_flag_reg)
    else $error("overflow not flagged on wrap");
  cnt_reload_a: assert property (cnt_lo_wr |=> counter_reg == tcc_pkg::CNT_RELOAD)
    else $error("counter not reloaded");
  force_level_a: assert property ((force_wr && pwdata[0] && !mode_active && !cmp_match[0])
    |=> compare_output_pin[0] == $past(level[0]) && $stable(compare_flag_reg[0]))
    else $error("force did not copy the level");

  cap_seen_c: cover property (cap_evt[1]);
  cmp_seen_c: cover property (cmp_match[0] && pin_en[0]);
  clear_seen_c: cover property (capture_flag_reg[0] ##1 !capture_flag_reg[0]);
  wrap_seen_c: cover property ($rose(overflow_flag_reg));
endmodule
`default_nettype wire

// [src/tcc_pkg.sv]
// Package of the capture/compare unit: register offsets, bit fields, reset values.
// Assumes a 32-bit APB with byte addresses; each 8-bit register sits in the low byte of a word.
package tcc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_TWO = 8'h00;
  localparam logic [7:0] OFS_CTRL_ONE = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_CAP1_HI = 8'h0C;
  localparam logic [7:0] OFS_CAP1_LO = 8'h10;
  localparam logic [7:0] OFS_CMP1_HI = 8'h14;
  localparam logic [7:0] OFS_CMP1_LO = 8'h18;
  localparam logic [7:0] OFS_CAP2_HI = 8'h1C;
  localparam logic [7:0] OFS_CAP2_LO = 8'h20;
  localparam logic [7:0] OFS_CMP2_HI = 8'h24;
  localparam logic [7:0] OFS_CMP2_LO = 8'h28;
  localparam logic [7:0] OFS_CNT_HI = 8'h2C;
  localparam logic [7:0] OFS_CNT_LO = 8'h30;
  localparam logic [7:0] OFS_ALT_HI = 8'h34;
  localparam logic [7:0] OFS_ALT_LO = 8'h38;
  localparam logic [7:0] OFS_FORCE = 8'h3C;
  // ----------------------------------------------------------------
  // Control register one fields
  // ----------------------------------------------------------------
  localparam int C1_CAP_IE = 7;
  localparam int C1_CMP_IE = 6;
  localparam int C1_OVF_IE = 5;
  localparam int C1_EDGE2 = 3;
  localparam int C1_LEVEL2 = 2;
  localparam int C1_EDGE1 = 1;
  localparam int C1_LEVEL1 = 0;
  // ----------------------------------------------------------------
  // Control register two fields
  // ----------------------------------------------------------------
  localparam int C2_PIN_EN1 = 7;
  localparam int C2_PIN_EN2 = 6;
  localparam int C2_OPM = 5;
  localparam int C2_PWM = 4;
  localparam int C2_CLKSEL_LO = 2;
  localparam int C2_EXT_EDGE = 1;
  // ----------------------------------------------------------------
  // Flag register fields
  // ----------------------------------------------------------------
  localparam int F_CAP1 = 7;
  localparam int F_CMP1 = 6;
  localparam int F_OVF = 5;
  localparam int F_CAP2 = 4;
  localparam int F_CMP2 = 3;
  // ----------------------------------------------------------------
  // Clock selections and reset values
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CLK_DIV2 = 2'h0,
    CLK_DIV4 = 2'h1,
    CLK_DIV8 = 2'h2,
    CLK_EXT = 2'h3
  } clk_sel_type;
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
  localparam logic [15:0] CNT_TOP = 16'hFFFF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
endpackage

// [tb/pin_partner.sv]
// Pin-side model: capture input levels and the external timer clock.
// Assumes the bench sets level requests just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level requests and pins
  input wire logic [1:0] level_req,
  output logic [1:0] capture_input_pin,
  output logic ext_clock_pin
);
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic [1:0] div_reg;
  // Active external edges stay eight CPU cycles apart.
  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= 2'h0;
      ext_clock_pin <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h3) begin
        ext_clock_pin <= ~ext_clock_pin;
      end
    end
  end
  always_ff @(posedge clk) begin
    capture_input_pin <= level_req;
  end
endmodule
`default_nettype wire

// [tb/timer_capture_compare_unit_test.sv]
// Self-checking bench of the capture/compare unit over APB.
// Assumes zero-wait APB and the pin model in pin_partner.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_unit_test;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} note_type;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, ext_clock_pin, timer_irq, cpu_irq_mask = 1'b0;
  logic [1:0] capture_input_pin, compare_output_pin, compare_pin_enable;
  logic [1:0] level_req = 2'h0;
  logic [15:0] r;
  note_type notes[$];
  int checks = 0, mismatches = 0;
  timer_capture_compare_unit u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_input_pin(capture_input_pin), .ext_clock_pin(ext_clock_pin),
    .compare_output_pin(compare_output_pin), .compare_pin_enable(compare_pin_enable),
    .cpu_irq_mask(cpu_irq_mask), .timer_irq(timer_irq));
  pin_partner u_pins (.clk(clk), .rst(rst), .level_req(level_req),
    .capture_input_pin(capture_input_pin), .ext_clock_pin(ext_clock_pin));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp_read(input note_type n, input logic [31:0] d, input logic e);
    checks++;
    if (((d & n.m) !== (n.d & n.m)) || (e !== n.e)) begin
      mismatches++;
      $display("[FAIL] %0t read %h err %b, expected %h", $time, d, e, n.d);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t pin or irq %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; a read notes its expectation for the monitor.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] m = 8'h00, input logic e = 1'b0);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    if (!w) notes.push_back('{{24'h0, d}, {24'h0, m} | {32{e}}, e});
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_pin(input int i, input logic v);
    int n;
    n = 0;
    while (compare_output_pin[i] !== v && n < 400) begin
      @(posedge clk);
      n++;
    end
    cmp_bit(compare_output_pin[i], v);
    if (n >= 400) stop_test();
  endtask
  // ----------------------------------------------------------------
  // Read monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
      if (notes.size() == 0) begin
        mismatches++;
        $display("[FAIL] %0t read without a note", $time);
      end else cmp_read(notes.pop_front(), prdata, pslverr);
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    r = 16'($urandom(53));
    cyc(8);
    rst <= 1'b0;
    cmp_bit(compare_output_pin[0], 1'b0);
    apb(0, tcc_pkg::OFS_CMP1_HI, 8'h80, 8'hFF);
    apb(0, tcc_pkg::OFS_CMP1_LO, 8'h00, 8'hFF);
    apb(0, 8'h40, 8'h00, 8'hFF, 1'b1);
    apb(1, tcc_pkg::OFS_CMP2_HI, r[15:8]);
    apb(0, tcc_pkg::OFS_FLAGS, 8'h00);
    apb(1, tcc_pkg::OFS_CMP2_LO, r[7:0]);
    apb(0, tcc_pkg::OFS_CMP2_HI, r[15:8], 8'hFF);
    apb(0, tcc_pkg::OFS_CMP2_LO, r[7:0], 8'hFF);
    apb(1, tcc_pkg::OFS_CTRL_ONE, 8'h82);
    level_req <= 2'h1;
    cyc(8);
    apb(0, tcc_pkg::OFS_FLAGS, 8'h80, 8'h80);
    cmp_bit(timer_irq, 1'b1);
    apb(0, tcc_pkg::OFS_CAP1_LO, 8'h00);
    apb(0, tcc_pkg::OFS_FLAGS, 8'h00, 8'h80);
    apb(0, tcc_pkg::OFS_CAP1_HI, 8'h00);
    level_req <= 2'h0;
    cyc(4);
    level_req <= 2'h1;
    cyc(8);
    apb(0, tcc_pkg::OFS_FLAGS, 8'h00, 8'h80);
    apb(0, tcc_pkg::OFS_CAP1_LO, 8'h00);
    apb(1, tcc_pkg::OFS_CTRL_ONE, 8'h80);
    level_req <= 2'h0;
    cyc(8);
    apb(0, tcc_pkg::OFS_FLAGS, 8'h80, 8'h80);
    cpu_irq_mask <= 1'b1;
    cyc(2);
    cmp_bit(timer_irq, 1'b0);
    apb(1, tcc_pkg::OFS_CTRL_TWO, 8'h80);
    apb(1, tcc_pkg::OFS_CTRL_ONE, 8'h01);
    apb(1, tcc_pkg::OFS_CMP1_HI, 8'h00);
    apb(1, tcc_pkg::OFS_CMP1_LO, 8'h20);
    apb(1, tcc_pkg::OFS_CNT_LO, 8'h00);
    wait_pin(0, 1'b1);
    cmp_bit(compare_pin_enable[0], 1'b1);
    apb(0, tcc_pkg::OFS_FLAGS, 8'h60, 8'h60);
    apb(1, tcc_pkg::OFS_CMP1_LO, 8'h20);
    apb(0, tcc_pkg::OFS_FLAGS, 8'h00, 8'h40);
    apb(1, tcc_pkg::OFS_CTRL_ONE, 8'h00);
    apb(1, tcc_pkg::OFS_FORCE, 8'h01);
    wait_pin(0, 1'b0);
    apb(0, tcc_pkg::OFS_FLAGS, 8'h00, 8'h40);
    apb(1, tcc_pkg::OFS_CTRL_TWO, 8'hA0);
    apb(1, tcc_pkg::OFS_CTRL_ONE, 8'h01);
    apb(1, tcc_pkg::OFS_FORCE, 8'h01);
    cyc(4);
    cmp_bit(compare_output_pin[0], 1'b0);
    cmp_bit(compare_output_pin[1], 1'b0);
    cmp_bit(compare_pin_enable[1], 1'b0);
    // Pulse mode: only capture channel 2 may still capture.
    apb(0, tcc_pkg::OFS_FLAGS, 8'h00);
    apb(0, tcc_pkg::OFS_CAP1_LO, 8'h00);
    apb(1, tcc_pkg::OFS_CTRL_ONE, 8'h0B);
    level_req <= 2'h3;
    cyc(8);
    apb(0, tcc_pkg::OFS_FLAGS, 8'h10, 8'h90);
    // External clock: the pin follows one count after the compare value.
    apb(1, tcc_pkg::OFS_CTRL_TWO, 8'h8E);
    apb(1, tcc_pkg::OFS_CTRL_ONE, 8'h01);
    apb(1, tcc_pkg::OFS_CMP1_HI, 8'h00);
    apb(1, tcc_pkg::OFS_CMP1_LO, 8'h02);
    apb(1, tcc_pkg::OFS_CNT_LO, 8'h00);
    wait_pin(0, 1'b1);
    apb(0, tcc_pkg::OFS_CNT_HI, 8'h00, 8'hFF);
    apb(0, tcc_pkg::OFS_CNT_LO, 8'h03, 8'hFF);
    cyc(4);
    stop_test();
  end
endmodule
`default_nettype wire
